// [uart_sync_serial_port_pkg.sv]
// Register map, reset values, field layouts and divider figures of the serial port.
// Assumes one 8-bit register per aligned 32-bit Wishbone word.
package uart_sync_serial_port_pkg;

  localparam logic [7:0] ADDR_TX_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_RX_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_BUFFER     = 8'h0c;
  localparam logic [7:0] ADDR_TMR_CNT    = 8'h10;
  localparam logic [7:0] ADDR_TMR_RELOAD = 8'h14;
  localparam logic [7:0] ADDR_TMR_CTRL   = 8'h18;
  localparam logic [7:0] ADDR_IRQ        = 8'h1c;

  localparam logic [7:0]  TX_CTRL_RESET   = 8'h04;
  localparam logic [7:0]  TX_CTRL_FIXED   = 8'h04;
  localparam logic [7:0]  RX_CTRL_RESET   = 8'h00;
  localparam logic [5:0]  STATUS_RESET    = 6'h00;
  localparam logic [7:0]  TMR_RESET       = 8'h00;
  localparam logic [3:0]  TMR_CTRL_RESET  = 4'h0;
  localparam logic [15:0] IRQ_VECTOR_ADDR = 16'h0038;

  localparam int          IRQ_REQ_BIT = 0;
  localparam int          IRQ_EN_BIT  = 1;
  localparam int          TMR_RUN_BIT = 3;

  localparam logic [3:0]  ASYNC_LAST  = 4'hf;
  localparam logic [3:0]  ASYNC_MID   = 4'h7;
  localparam logic [1:0]  SYNC_LAST   = 2'h3;
  localparam logic [1:0]  SYNC_SAMPLE = 2'h2;

  typedef struct packed {
    logic tx_done_irq_enable;
    logic tx_empty_irq_enable;
    logic tx_parity_odd;
    logic tx_parity_enable;
    logic tx_stop_length;
    logic fixed_one;
    logic tx_length_select;
    logic tx_mode_select;
  } tx_ctrl_t;

  typedef struct packed {
    logic rx_enable;
    logic rx_complete_irq_enable;
    logic rx_parity_odd;
    logic rx_parity_enable;
    logic rx_master_slave_select;
    logic ext_baud_clock;
    logic rx_length_select;
    logic rx_mode_select;
  } rx_ctrl_t;

  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic tx_empty;
    logic parity_err;
    logic overrun_err;
    logic framing_err;
  } status_t;

endpackage : uart_sync_serial_port_pkg

// [uart_sync_serial_port.sv]
// Serial port channel: UART and clocked synchronous modes, baud timer, Wishbone slave.
// Assumes pins arrive asynchronous to clk_i; reset sources are pulses on clk_i.
// Contract
// - Receive-control bit 0 picks synchronous (1) or asynchronous (0) reception.
// - In synchronous receive, bit 1 picks 7/8 bits, bit 3 master or slave.
// - Receive-control bit 6 gates receive-complete onto the interrupt request.
// - Reception happens only while receive-control bit 7 is set.
// - Writing the buffer register starts a transmission.
// - Master drives the shift clock pin; in slave mode the remote drives it.
// - Writing the timer counter also loads the same value into the reload register.
// - Timer control bits 0-2 pick count clock; bit 3 runs or halts the timer.
// - Bit rate is timer clock over (256 - reload), then over 16 or 4.
// - All three events set one shared request flag, gated by the enable flag.
// - Transmit and receive length are 7 or 8 bits in both modes.
// - Asynchronous transmit sends 1 or 2 stop bits as configured.
// - Transmit and receive are double buffered and run at the same time.
// - Transmit-control bits 4 and 5 give parity enable and odd/even, async only.
// - Transmit-control bit 3 is stop length async, master/slave sync.
// - Transmit-control bit 0 picks mode, bit 1 picks 7/8 bit length.
// - Transmit-control bits 6 and 7 gate buffer-empty and complete interrupts.
// - Transmit-control bit 2 ignores writes and reads back 1.
// - Any reset source sets transmit control to 04H.
// - Transmitter and receiver share one baud source chosen by receive control.
// - A 7-bit reception reads 1 in buffer bit 7.
// - Status flags stay set until software clears them.
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module uart_sync_serial_port #(
  parameter int PRESC_W = 7
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        break_instruction_i,
  input  wire logic        watchdog_overflow_i,
  input  wire logic        opcode_trap_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        serial_rx_pin_i,
  output logic             serial_tx_pin_o,
  input  wire logic        tx_clock_pin_i,
  output logic             tx_clock_pin_o,
  output logic             tx_clock_pin_oe_n_o,
  input  wire logic        rx_clock_pin_i,
  output logic             rx_clock_pin_o,
  output logic             rx_clock_pin_oe_n_o,
  output logic             serial_irq_o
);

  // Prescaler must cover the widest count clock select
  if (PRESC_W < 7) begin : g_presc_check
    $error("PRESC_W must be at least 7");
  end

  // Pin, break, watchdog and trap resets act alike
  logic srst;
  assign srst = rst_i | break_instruction_i | watchdog_overflow_i | opcode_trap_i;

  // Three-stage pin synchronisers: 0 rx data, 1 tx clock, 2 rx clock
  logic [2:0] pin_in;
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] filt_reg;
  logic [2:0] filt_d_reg;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  assign pin_in = {rx_clock_pin_i, tx_clock_pin_i, serial_rx_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (srst) begin
          s1_reg[gi]     <= 1'b1;
          s2_reg[gi]     <= 1'b1;
          s3_reg[gi]     <= 1'b1;
          filt_reg[gi]   <= 1'b1;
          filt_d_reg[gi] <= 1'b1;
        end else begin
          s1_reg[gi]     <= pin_in[gi];
          s2_reg[gi]     <= s1_reg[gi];
          s3_reg[gi]     <= s2_reg[gi];
          filt_d_reg[gi] <= filt_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            filt_reg[gi] <= s3_reg[gi];
          end
        end
      end
      assign pin_rise[gi] = filt_reg[gi] & ~filt_d_reg[gi];
      assign pin_fall[gi] = ~filt_reg[gi] & filt_d_reg[gi];
    end
  endgenerate

  // Register file state
  uart_sync_serial_port_pkg::tx_ctrl_t tx_ctrl_reg;
  uart_sync_serial_port_pkg::rx_ctrl_t rx_ctrl_reg;
  uart_sync_serial_port_pkg::status_t  status_reg;
  uart_sync_serial_port_pkg::status_t  events;
  logic [7:0]         rx_buf_reg;
  logic               rx_unread_reg;
  logic [7:0]         tx_hold_reg;
  logic               tx_full_reg;
  logic [7:0]         tmr_cnt_reg;
  logic [7:0]         tmr_reload_reg;
  logic [3:0]         tmr_ctrl_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic               tmr_ovf_reg;
  logic               irq_req_reg;
  logic               irq_en_reg;
  logic               ack_reg;
  logic [31:0]        dat_reg;

  // Wishbone decode: work on the first cycle, ack on the next
  logic access;
  logic wr;
  logic rd;
  assign access = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr     = access & wb_we_i & wb_sel_i[0];
  assign rd     = access & ~wb_we_i;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  always_ff @(posedge clk_i) begin
    if (srst) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= access;
      if (rd) begin
        case (wb_adr_i)
          uart_sync_serial_port_pkg::ADDR_TX_CTRL:    dat_reg <= {24'h000000, tx_ctrl_reg};
          uart_sync_serial_port_pkg::ADDR_RX_CTRL:    dat_reg <= {24'h000000, rx_ctrl_reg};
          uart_sync_serial_port_pkg::ADDR_STATUS:     dat_reg <= {26'h0, status_reg};
          uart_sync_serial_port_pkg::ADDR_BUFFER:     dat_reg <= {24'h000000, rx_buf_reg};
          uart_sync_serial_port_pkg::ADDR_TMR_CNT:    dat_reg <= {24'h000000, tmr_cnt_reg};
          uart_sync_serial_port_pkg::ADDR_TMR_RELOAD: dat_reg <= {24'h000000, tmr_reload_reg};
          uart_sync_serial_port_pkg::ADDR_TMR_CTRL:   dat_reg <= {28'h0000000, tmr_ctrl_reg};
          uart_sync_serial_port_pkg::ADDR_IRQ:        dat_reg <= {30'h0, irq_en_reg, irq_req_reg};
          default:                                    dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (srst) begin
      tx_ctrl_reg <= uart_sync_serial_port_pkg::TX_CTRL_RESET;
      rx_ctrl_reg <= uart_sync_serial_port_pkg::RX_CTRL_RESET;
    end else if (wr) begin
      if (wb_adr_i == uart_sync_serial_port_pkg::ADDR_TX_CTRL) begin
        tx_ctrl_reg <= wb_dat_i[7:0] | uart_sync_serial_port_pkg::TX_CTRL_FIXED;
      end
      if (wb_adr_i == uart_sync_serial_port_pkg::ADDR_RX_CTRL) begin
        rx_ctrl_reg <= wb_dat_i[7:0];
      end
    end
  end

  // Baud timer: prescaled count clock, reload on overflow
  logic [7:0] tmr_mask;
  logic       tmr_tick;
  logic       brg_tick;
  assign tmr_mask = (8'h01 << tmr_ctrl_reg[2:0]) - 8'h01;
  assign tmr_tick = (presc_reg[6:0] & tmr_mask[6:0]) == tmr_mask[6:0];

  always_ff @(posedge clk_i) begin
    if (srst) begin
      tmr_cnt_reg    <= uart_sync_serial_port_pkg::TMR_RESET;
      tmr_reload_reg <= uart_sync_serial_port_pkg::TMR_RESET;
      tmr_ctrl_reg   <= uart_sync_serial_port_pkg::TMR_CTRL_RESET;
      presc_reg      <= '0;
      tmr_ovf_reg    <= 1'b0;
    end else begin
      presc_reg   <= presc_reg + 1'b1;
      tmr_ovf_reg <= 1'b0;
      if (wr && wb_adr_i == uart_sync_serial_port_pkg::ADDR_TMR_CTRL) begin
        tmr_ctrl_reg <= wb_dat_i[3:0];
      end
      if (wr && wb_adr_i == uart_sync_serial_port_pkg::ADDR_TMR_CNT) begin
        tmr_cnt_reg    <= wb_dat_i[7:0];
        tmr_reload_reg <= wb_dat_i[7:0];
      end else if (tmr_ctrl_reg[uart_sync_serial_port_pkg::TMR_RUN_BIT] && tmr_tick) begin
        if (tmr_cnt_reg == 8'hff) begin
          tmr_cnt_reg <= tmr_reload_reg;
          tmr_ovf_reg <= 1'b1;
        end else begin
          tmr_cnt_reg <= tmr_cnt_reg + 8'h01;
        end
      end
    end
  end

  // One baud source for both directions
  assign brg_tick = rx_ctrl_reg.ext_baud_clock ? pin_rise[2] : tmr_ovf_reg;

  // Transmit frame assembly
  logic        tx_sync;
  logic        tx_slave;
  logic [3:0]  tx_dlen;
  logic [7:0]  tx_data;
  logic        tx_par;
  logic [11:0] tx_frame;
  logic [3:0]  tx_bits;
  assign tx_sync  = tx_ctrl_reg.tx_mode_select;
  assign tx_slave = tx_sync & tx_ctrl_reg.tx_stop_length;
  assign tx_dlen  = tx_ctrl_reg.tx_length_select ? 4'd7 : 4'd8;
  assign tx_data  = tx_ctrl_reg.tx_length_select ? {1'b0, tx_hold_reg[6:0]} : tx_hold_reg;
  assign tx_par   = (^tx_data) ^ tx_ctrl_reg.tx_parity_odd;

  always_comb begin
    tx_frame = 12'hfff;
    tx_bits  = tx_dlen;
    if (tx_sync) begin
      tx_frame[7:0] = tx_data;
    end else begin
      tx_frame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i < int'(tx_dlen)) begin
          tx_frame[i+1] = tx_data[i];
        end
      end
      if (tx_ctrl_reg.tx_parity_enable) begin
        tx_frame[tx_dlen+4'd1] = tx_par;
      end
      tx_bits = 4'd1 + tx_dlen + {3'b000, tx_ctrl_reg.tx_parity_enable}
              + (tx_ctrl_reg.tx_stop_length ? 4'd1 : 4'd2);
    end
  end

  // Transmit engine
  logic        tx_busy_reg;
  logic [11:0] tx_shift_reg;
  logic [3:0]  tx_left_reg;
  logic [3:0]  tx_cnt_reg;
  logic        tx_line_reg;
  logic        tx_load;
  logic        tx_bit_end;
  assign tx_load = ~tx_busy_reg & tx_full_reg;

  always_comb begin
    if (!tx_sync) begin
      tx_bit_end = brg_tick & (tx_cnt_reg == uart_sync_serial_port_pkg::ASYNC_LAST);
    end else if (!tx_slave) begin
      tx_bit_end = brg_tick & (tx_cnt_reg[1:0] == uart_sync_serial_port_pkg::SYNC_LAST);
    end else begin
      tx_bit_end = pin_rise[1];
    end
    tx_bit_end = tx_bit_end & tx_busy_reg;
  end

  always_ff @(posedge clk_i) begin
    if (srst) begin
      tx_hold_reg <= 8'h00;
      tx_full_reg <= 1'b0;
    end else if (wr && wb_adr_i == uart_sync_serial_port_pkg::ADDR_BUFFER) begin
      tx_hold_reg <= wb_dat_i[7:0];
      tx_full_reg <= 1'b1;
    end else if (tx_load) begin
      tx_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst) begin
      tx_busy_reg  <= 1'b0;
      tx_shift_reg <= 12'hfff;
      tx_left_reg  <= 4'h0;
      tx_cnt_reg   <= 4'h0;
      tx_line_reg  <= 1'b1;
    end else if (tx_load) begin
      tx_busy_reg  <= 1'b1;
      tx_shift_reg <= tx_frame;
      tx_line_reg  <= tx_frame[0];
      tx_left_reg  <= tx_bits;
      tx_cnt_reg   <= 4'h0;
    end else if (tx_busy_reg) begin
      if (brg_tick) begin
        tx_cnt_reg <= tx_cnt_reg + 4'h1;
      end
      if (tx_bit_end) begin
        if (tx_left_reg == 4'h1) begin
          tx_busy_reg <= 1'b0;
          tx_line_reg <= 1'b1;
        end else begin
          tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
          tx_line_reg  <= tx_shift_reg[1];
          tx_left_reg  <= tx_left_reg - 4'h1;
        end
      end
    end
  end

  assign serial_tx_pin_o     = tx_line_reg;
  assign tx_clock_pin_o      = ~(tx_busy_reg & tx_sync & ~tx_slave) | tx_cnt_reg[1];
  assign tx_clock_pin_oe_n_o = ~(tx_sync & ~tx_slave);

  // Receive engine
  logic        rx_sync;
  logic        rx_slave;
  logic        rx_en;
  logic [3:0]  rx_dlen;
  logic [3:0]  rx_bits;
  logic        rx_busy_reg;
  logic [3:0]  rx_idx_reg;
  logic [3:0]  rx_cnt_reg;
  logic [11:0] rx_frame_reg;
  logic [11:0] rx_frame_w;
  logic        rx_sample;
  logic        rx_start;
  logic        rx_done;
  logic        rx_false_start;
  logic [7:0]  rx_data;
  logic        rx_perr;
  logic        rx_ferr;
  assign rx_sync  = rx_ctrl_reg.rx_mode_select;
  assign rx_slave = rx_sync & rx_ctrl_reg.rx_master_slave_select;
  assign rx_en    = rx_ctrl_reg.rx_enable;
  assign rx_dlen  = rx_ctrl_reg.rx_length_select ? 4'd7 : 4'd8;
  assign rx_bits  = rx_sync ? rx_dlen : 4'd2 + rx_dlen + {3'b000, rx_ctrl_reg.rx_parity_enable};
  assign rx_start = ~rx_busy_reg & rx_en & (rx_sync | pin_fall[0]);

  always_comb begin
    if (!rx_sync) begin
      rx_sample = brg_tick & (rx_cnt_reg == uart_sync_serial_port_pkg::ASYNC_MID);
    end else if (!rx_slave) begin
      rx_sample = brg_tick & (rx_cnt_reg[1:0] == uart_sync_serial_port_pkg::SYNC_SAMPLE);
    end else begin
      rx_sample = pin_rise[2];
    end
    rx_sample = rx_sample & rx_busy_reg & rx_en;
    rx_frame_w = rx_frame_reg;
    rx_frame_w[rx_idx_reg] = filt_reg[0];
  end

  assign rx_false_start = rx_sample & ~rx_sync & (rx_idx_reg == 4'h0) & filt_reg[0];
  assign rx_done        = rx_sample & ~rx_false_start & (rx_idx_reg == rx_bits - 4'h1);
  assign rx_data        = rx_sync ? rx_frame_w[7:0] : rx_frame_w[8:1];
  assign rx_perr = ~rx_sync & rx_ctrl_reg.rx_parity_enable
                 & (((^rx_data[6:0]) ^ (~rx_ctrl_reg.rx_length_select & rx_data[7])
                    ^ rx_frame_w[rx_dlen+4'd1]) != rx_ctrl_reg.rx_parity_odd);
  assign rx_ferr = ~rx_sync
                 & ~rx_frame_w[rx_dlen+4'd1+{3'b000, rx_ctrl_reg.rx_parity_enable}];

  always_ff @(posedge clk_i) begin
    if (srst) begin
      rx_busy_reg  <= 1'b0;
      rx_idx_reg   <= 4'h0;
      rx_cnt_reg   <= 4'h0;
      rx_frame_reg <= 12'hfff;
    end else if (!rx_en) begin
      rx_busy_reg <= 1'b0;
    end else if (rx_start) begin
      rx_busy_reg <= 1'b1;
      rx_idx_reg  <= 4'h0;
      rx_cnt_reg  <= 4'h0;
    end else if (rx_busy_reg) begin
      if (brg_tick) begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
      if (rx_sample) begin
        rx_frame_reg <= rx_frame_w;
        rx_idx_reg   <= rx_idx_reg + 4'h1;
        if (rx_false_start || rx_done) begin
          rx_busy_reg <= 1'b0;
        end
      end
    end
  end

  // Receive buffer holds data until the next completion
  always_ff @(posedge clk_i) begin
    if (srst) begin
      rx_buf_reg    <= 8'h00;
      rx_unread_reg <= 1'b0;
    end else if (rx_done) begin
      rx_buf_reg    <= rx_ctrl_reg.rx_length_select ? {1'b1, rx_data[6:0]} : rx_data;
      rx_unread_reg <= 1'b1;
    end else if (rd && wb_adr_i == uart_sync_serial_port_pkg::ADDR_BUFFER) begin
      rx_unread_reg <= 1'b0;
    end
  end

  assign rx_clock_pin_o      = ~(rx_busy_reg & rx_sync & ~rx_slave) | rx_cnt_reg[1];
  assign rx_clock_pin_oe_n_o = ~(rx_sync & ~rx_slave);

  // Status flags: hardware only sets, set beats a software clear
  always_comb begin
    events.rx_done     = rx_done;
    events.tx_done     = tx_bit_end & (tx_left_reg == 4'h1);
    events.tx_empty    = tx_load;
    events.parity_err  = rx_done & rx_perr;
    events.overrun_err = rx_done & rx_unread_reg;
    events.framing_err = rx_done & rx_ferr;
  end

  always_ff @(posedge clk_i) begin
    if (srst) begin
      status_reg <= uart_sync_serial_port_pkg::STATUS_RESET;
    end else if (wr && wb_adr_i == uart_sync_serial_port_pkg::ADDR_STATUS) begin
      status_reg <= wb_dat_i[5:0] | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  // Shared request flag and its enable
  logic irq_set;
  assign irq_set = (events.tx_empty & tx_ctrl_reg.tx_empty_irq_enable)
                 | (events.tx_done & tx_ctrl_reg.tx_done_irq_enable)
                 | (events.rx_done & rx_ctrl_reg.rx_complete_irq_enable);

  always_ff @(posedge clk_i) begin
    if (srst) begin
      irq_req_reg <= 1'b0;
      irq_en_reg  <= 1'b0;
    end else if (wr && wb_adr_i == uart_sync_serial_port_pkg::ADDR_IRQ) begin
      irq_req_reg <= wb_dat_i[uart_sync_serial_port_pkg::IRQ_REQ_BIT] | irq_set;
      irq_en_reg  <= wb_dat_i[uart_sync_serial_port_pkg::IRQ_EN_BIT];
    end else begin
      irq_req_reg <= irq_req_reg | irq_set;
    end
  end

  assign serial_irq_o = irq_req_reg & irq_en_reg;

endmodule : uart_sync_serial_port

// [uart_sync_serial_port_sva.sv]
// Concurrent checks on the serial port's bus answers and pin behaviour.
// Bound to the port's top module; sees its ports only.
`timescale 1ns/1ps
module uart_sync_serial_port_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        break_instruction_i,
  input wire logic        watchdog_overflow_i,
  input wire logic        opcode_trap_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        serial_tx_pin_o,
  input wire logic        tx_clock_pin_o,
  input wire logic        tx_clock_pin_oe_n_o,
  input wire logic        rx_clock_pin_oe_n_o,
  input wire logic        serial_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic rd_ack;
  logic irq_wr;
  assign rd_ack = wb_ack_o && !wb_we_i;
  assign irq_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == uart_sync_serial_port_pkg::ADDR_IRQ;

  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("ack without request");
  read_upper_a: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (rd_ack && wb_adr_i > 8'h1c |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  fixed_bit_a: assert property (rd_ack && wb_adr_i == uart_sync_serial_port_pkg::ADDR_TX_CTRL |-> wb_dat_o[2])
    else $error("transmit control bit 2 reads 0");
  status_width_a: assert property (rd_ack && wb_adr_i == uart_sync_serial_port_pkg::ADDR_STATUS |-> wb_dat_o[7:6] == 2'h0)
    else $error("status upper bits set");
  reset_idle_a: assert property (break_instruction_i || watchdog_overflow_i || opcode_trap_i |=> serial_tx_pin_o && tx_clock_pin_oe_n_o && rx_clock_pin_oe_n_o && !serial_irq_o && !wb_ack_o)
    else $error("outputs not idle after reset source");
  irq_gate_a: assert property (irq_wr && !wb_dat_i[1] |-> !serial_irq_o)
    else $error("irq out while disabled");
  irq_set_a: assert property (irq_wr && wb_dat_i[1:0] == 2'h3 |-> serial_irq_o)
    else $error("irq out missing");
  async_bit_a: assert property ($changed(serial_tx_pin_o) && tx_clock_pin_oe_n_o |=> $stable(serial_tx_pin_o)[*8])
    else $error("async bit too short");
  sync_high_a: assert property (!tx_clock_pin_oe_n_o && $rose(tx_clock_pin_o) |=> tx_clock_pin_o)
    else $error("shift clock high too short");
  sync_data_a: assert property (!tx_clock_pin_oe_n_o && $rose(tx_clock_pin_o) |-> $stable(serial_tx_pin_o))
    else $error("data moved at rising shift clock");

  cover property (wb_ack_o && wb_we_i && wb_adr_i == uart_sync_serial_port_pkg::ADDR_BUFFER);
  cover property ($rose(serial_irq_o));
  cover property (!tx_clock_pin_oe_n_o && $fell(tx_clock_pin_o));
endmodule : uart_sync_serial_port_sva

// [serial_remote_model.sv]
// Remote serial device: echoes line data, gives an external baud clock.
// A released transmit clock pin reads high; a released receive clock pin carries the remote baud clock.
`timescale 1ns/1ps
module serial_remote_model (
  input  wire logic link_en_i,
  input  wire logic tx_pin_i,
  output logic      rx_pin_o,
  input  wire logic tx_clk_i,
  input  wire logic tx_clk_oe_n_i,
  output logic      tx_clk_o,
  input  wire logic rx_clk_i,
  input  wire logic rx_clk_oe_n_i,
  output logic      rx_clk_o
);
  logic baud_clk = 1'b1;
  initial rx_pin_o = 1'b1;
  always #24 baud_clk = link_en_i ? ~baud_clk : 1'b1;
  always @(tx_pin_i) rx_pin_o <= #7 tx_pin_i;
  assign tx_clk_o = tx_clk_oe_n_i ? 1'b1 : tx_clk_i;
  assign rx_clk_o = rx_clk_oe_n_i ? baud_clk : rx_clk_i;
endmodule : serial_remote_model

// [uart_sync_serial_port_tb.sv]
// Self-checking bench: Wishbone register tests and frame captures.
// Remote model echoes transmit data to the receiver.
`timescale 1ns/1ps
module uart_sync_serial_port_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [2:0]  rsrc = 3'h0;
  logic        break_instruction_i, watchdog_overflow_i, opcode_trap_i;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, serial_rx_pin_i, serial_tx_pin_o, serial_irq_o, link_en = 1'b0;
  logic        tx_clock_pin_i, tx_clock_pin_o, tx_clock_pin_oe_n_o;
  logic        rx_clock_pin_i, rx_clock_pin_o, rx_clock_pin_oe_n_o;
  int          num_errors = 0, checks = 0;
  assign {opcode_trap_i, break_instruction_i, watchdog_overflow_i} = rsrc;
  always #2.5 clk_i = ~clk_i;
  uart_sync_serial_port uart_sync_serial_port_i (.*);
  serial_remote_model serial_remote_model_i (.link_en_i(link_en), .tx_pin_i(serial_tx_pin_o),
    .rx_pin_o(serial_rx_pin_i), .tx_clk_i(tx_clock_pin_o), .tx_clk_oe_n_i(tx_clock_pin_oe_n_o),
    .tx_clk_o(tx_clock_pin_i), .rx_clk_i(rx_clock_pin_o), .rx_clk_oe_n_i(rx_clock_pin_oe_n_o),
    .rx_clk_o(rx_clock_pin_i));

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic tick(inout int n);
    @(posedge clk_i);
    n++;
    if (n > 2000) begin
      num_errors++;
      conclude();
    end
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= {24'h0, wd};
    do begin
      tick(n);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, adr, d, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] r;
    wb(1'b0, adr, 8'h00, r);
    chk({24'h0, r}, {24'h0, exp});
  endtask : rd_chk
  task automatic poll(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] r;
    int n;
    n = 0;
    do begin
      wb(1'b0, adr, 8'h00, r);
      n += 4;
    end while (r !== exp && n < 1600);
    chk({24'h0, r}, {24'h0, exp});
  endtask : poll
  // Async frame on the tx pin, sampled mid-bit; bt is clocks per bit
  task automatic frame(input int nb, input logic [1:0] par, input int nstop, input int bt, input logic [7:0] exp);
    logic [7:0] d;
    int n;
    d = 8'h00;
    n = 0;
    while (serial_tx_pin_o !== 1'b0) tick(n);
    repeat (bt / 2) @(posedge clk_i);
    chk({31'h0, serial_tx_pin_o}, 32'h0);
    for (int i = 0; i < nb; i++) begin
      repeat (bt) @(posedge clk_i);
      d[i] = serial_tx_pin_o;
    end
    chk({24'h0, d}, {24'h0, exp});
    if (par[1]) begin
      repeat (bt) @(posedge clk_i);
      chk({31'h0, serial_tx_pin_o}, {31'h0, par[0]});
    end
    for (int i = 0; i < nstop; i++) begin
      repeat (bt) @(posedge clk_i);
      chk({31'h0, serial_tx_pin_o}, 32'h1);
    end
  endtask : frame
  task automatic sync_frame(input logic [7:0] exp);
    logic [7:0] d;
    int n;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      while (tx_clock_pin_i !== 1'b0) tick(n);
      while (tx_clock_pin_i !== 1'b1) tick(n);
      d[i] = serial_tx_pin_o;
    end
    chk({24'h0, d}, {24'h0, exp});
  endtask : sync_frame

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(uart_sync_serial_port_pkg::ADDR_TX_CTRL, 8'h04);
    rd_chk(uart_sync_serial_port_pkg::ADDR_RX_CTRL, 8'h00);
    rd_chk(uart_sync_serial_port_pkg::ADDR_STATUS, 8'h00);
    rd_chk(8'h24, 8'h00);
    wr(uart_sync_serial_port_pkg::ADDR_TX_CTRL, 8'hf0);
    rd_chk(uart_sync_serial_port_pkg::ADDR_TX_CTRL, 8'hf4);
    wr(uart_sync_serial_port_pkg::ADDR_TMR_CNT, 8'hfe);
    rd_chk(uart_sync_serial_port_pkg::ADDR_TMR_RELOAD, 8'hfe);
    wr(uart_sync_serial_port_pkg::ADDR_TMR_CTRL, 8'h08);
    $display("test registers done");
    wr(uart_sync_serial_port_pkg::ADDR_TX_CTRL, 8'h04);
    wr(uart_sync_serial_port_pkg::ADDR_RX_CTRL, 8'h80);
    wr(uart_sync_serial_port_pkg::ADDR_BUFFER, 8'ha5);
    wr(uart_sync_serial_port_pkg::ADDR_BUFFER, 8'h3c);
    frame(8, 2'b00, 2, 32, 8'ha5);
    frame(8, 2'b00, 2, 32, 8'h3c);
    poll(uart_sync_serial_port_pkg::ADDR_STATUS, 8'h3a);
    rd_chk(uart_sync_serial_port_pkg::ADDR_BUFFER, 8'h3c);
    wr(uart_sync_serial_port_pkg::ADDR_STATUS, 8'h00);
    rd_chk(uart_sync_serial_port_pkg::ADDR_STATUS, 8'h00);
    $display("test async two stop done");
    link_en <= 1'b1;
    wr(uart_sync_serial_port_pkg::ADDR_TX_CTRL, 8'h3a);
    wr(uart_sync_serial_port_pkg::ADDR_RX_CTRL, 8'hb6);
    wr(uart_sync_serial_port_pkg::ADDR_BUFFER, 8'h35);
    frame(7, 2'b11, 1, 154, 8'h35);
    poll(uart_sync_serial_port_pkg::ADDR_STATUS, 8'h38);
    rd_chk(uart_sync_serial_port_pkg::ADDR_BUFFER, 8'hb5);
    link_en <= 1'b0;
    $display("test external baud done");
    wr(uart_sync_serial_port_pkg::ADDR_STATUS, 8'h00);
    wr(uart_sync_serial_port_pkg::ADDR_TX_CTRL, 8'h48);
    wr(uart_sync_serial_port_pkg::ADDR_RX_CTRL, 8'h40);
    wr(uart_sync_serial_port_pkg::ADDR_IRQ, 8'h02);
    wr(uart_sync_serial_port_pkg::ADDR_BUFFER, 8'h11);
    frame(8, 2'b00, 1, 32, 8'h11);
    poll(uart_sync_serial_port_pkg::ADDR_STATUS, 8'h18);
    rd_chk(uart_sync_serial_port_pkg::ADDR_IRQ, 8'h03);
    chk({31'h0, serial_irq_o}, 32'h1);
    wr(uart_sync_serial_port_pkg::ADDR_IRQ, 8'h01);
    chk({31'h0, serial_irq_o}, 32'h0);
    wr(uart_sync_serial_port_pkg::ADDR_IRQ, 8'h03);
    $display("test interrupt done");
    wr(uart_sync_serial_port_pkg::ADDR_STATUS, 8'h00);
    wr(uart_sync_serial_port_pkg::ADDR_TX_CTRL, 8'h01);
    chk({31'h0, tx_clock_pin_oe_n_o}, 32'h0);
    wr(uart_sync_serial_port_pkg::ADDR_BUFFER, 8'h96);
    sync_frame(8'h96);
    poll(uart_sync_serial_port_pkg::ADDR_STATUS, 8'h18);
    wr(uart_sync_serial_port_pkg::ADDR_TX_CTRL, 8'h08);
    $display("test sync master done");
    for (int k = 0; k < 3; k++) begin
      wr(uart_sync_serial_port_pkg::ADDR_TX_CTRL, 8'h09);
      rsrc <= 3'h1 << k;
      @(posedge clk_i);
      rsrc <= 3'h0;
      rd_chk(uart_sync_serial_port_pkg::ADDR_TX_CTRL, 8'h04);
    end
    $display("test reset sources done");
    conclude();
  end
endmodule : uart_sync_serial_port_tb

bind uart_sync_serial_port uart_sync_serial_port_sva uart_sync_serial_port_sva_i (.*);
